/* hdl/bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Data
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end

endmodule : bit_sync

`default_nettype wire

/* hdl/fault_map.svh */
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH

`define REG_FAULT_FLAGS 8'hd0
`define REG_FAULT_IGNORE_MASK 8'hd1
`define REG_FAULT_RECOVERY_SELECT 8'hd2
`define CMD_CLEAR_FAULTS 8'h03

`define BIT_INPUT_OV 2
`define BIT_OUTPUT_UV 6
`define BIT_OUTPUT_OV 7

`define MASK_RESET 8'h40
`define FLAGS_RESET 8'h00
`define READ_UNMAPPED 8'h00

`define SMB_ADDR_DEFAULT 7'h20

`define MCLK_HZ 20000000
`define INIT_WAIT_US 1000
`define HICCUP_WAIT_MS 500
`define STRAP_SETTLE 2'h3

`endif

/* hdl/fault_pkg.sv */
package fault_pkg;

	typedef logic [7:0] fault_vec_t;

	typedef enum logic [1:0] {
		EV_POINT,
		EV_WRITE,
		EV_CLEAR
	} ev_kind_t;

	typedef struct packed {
		ev_kind_t kind;
		logic [7:0] cmd;
		logic [7:0] data;
	} link_event_t;

	typedef enum logic [2:0] {
		PS_OFF,
		PS_INIT,
		PS_RUN,
		PS_HICCUP,
		PS_LATCHED
	} pwr_state_t;

	typedef enum logic [2:0] {
		LK_IDLE,
		LK_ADDR,
		LK_CMD,
		LK_DATA,
		LK_READ
	} link_phase_t;

endpackage : fault_pkg

/* hdl/fault_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fault_map.svh"

module fault_supervisor
	import fault_pkg::*;
#(
	parameter logic [6:0] SMB_ADDR = `SMB_ADDR_DEFAULT,
	parameter int INIT_CYCLES = `INIT_WAIT_US * (`MCLK_HZ / 1000000),
	parameter int HICCUP_CYCLES = `HICCUP_WAIT_MS * (`MCLK_HZ / 1000)
) (
	// System clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Enable, strap and fault comparators
	input wire logic enable_in,
	input wire logic recovery_default_pin_in,
	input wire logic input_overvoltage_in,
	input wire logic output_undervoltage_in,
	input wire logic output_overvoltage_in,
	input wire logic [7:0] other_fault_in,
	// Power stage control
	output logic switching_on_out,
	output logic soft_start_out,
	output logic latched_off_out,
	// Alert pin, open drain
	output logic fault_alert_out,
	output logic fault_alert_oe_n_out,
	// PMBus link
	input wire logic smb_clk_in,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n_out
);

	localparam int CNT_W = 24;

	// Register read decode
	function automatic logic [7:0] reg_read(input logic [7:0] addr, input fault_vec_t flags,
			input fault_vec_t mask, input fault_vec_t resp);
		logic [7:0] val;
		val = `READ_UNMAPPED;
		if (addr == `REG_FAULT_FLAGS) begin
			val = flags;
		end else if (addr == `REG_FAULT_IGNORE_MASK) begin
			val = mask;
		end else if (addr == `REG_FAULT_RECOVERY_SELECT) begin
			val = resp;
		end
		return val;
	endfunction : reg_read

	function automatic logic wr_hit(input link_event_t ev, input logic [7:0] addr);
		return (ev.kind == EV_WRITE) && (ev.cmd == addr);
	endfunction : wr_hit

	// ---------------- System clock domain ----------------

	fault_vec_t fault_raw;
	logic [9:0] pin_sync;
	logic enable_s;
	logic strap_s;
	fault_vec_t fault_s;

	always_comb begin
		fault_raw = other_fault_in;
		fault_raw[`BIT_INPUT_OV] = input_overvoltage_in;
		fault_raw[`BIT_OUTPUT_UV] = output_undervoltage_in;
		fault_raw[`BIT_OUTPUT_OV] = output_overvoltage_in;
	end

	bit_sync #(
		.WIDTH(10)
	) u_pin_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.d_in({enable_in, recovery_default_pin_in, fault_raw}),
		.q_out(pin_sync)
	);

	assign enable_s = pin_sync[9];
	assign strap_s = pin_sync[8];
	assign fault_s = pin_sync[7:0];

	// Link events arrive by toggle; the event word is stable while the toggle settles
	link_event_t ev_r;
	logic ev_tog_r;
	logic ev_tog_s;
	logic ev_tog_d_r;
	logic ev_fire;

	bit_sync #(
		.WIDTH(1)
	) u_ev_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.d_in(ev_tog_r),
		.q_out(ev_tog_s)
	);

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ev_tog_d_r <= 1'b0;
		end else begin
			ev_tog_d_r <= ev_tog_s;
		end
	end

	assign ev_fire = ev_tog_s ^ ev_tog_d_r;

	// Fault flags
	fault_vec_t flags_r;
	fault_vec_t flags_nxt;
	fault_vec_t flag_set;
	fault_vec_t flag_clear;

	always_comb begin
		flag_set = fault_s & {8{enable_s}};
		flag_clear = '0;
		if (!enable_s) begin
			flag_clear = '1;
		end
		if (ev_fire && ev_r.kind == EV_CLEAR) begin
			flag_clear = '1;
		end
		if (ev_fire && wr_hit(ev_r, `REG_FAULT_FLAGS)) begin
			flag_clear = flag_clear | ev_r.data;
		end
		// While enabled, a fault present in the clearing cycle keeps its flag
		flags_nxt = (flags_r & ~flag_clear) | flag_set;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			flags_r <= `FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Ignore mask
	fault_vec_t mask_r;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			mask_r <= `MASK_RESET;
		end else if (ev_fire && wr_hit(ev_r, `REG_FAULT_IGNORE_MASK)) begin
			mask_r <= ev_r.data;
		end
	end

	// Recovery select, loaded from the strap once the synchroniser has settled
	fault_vec_t resp_r;
	logic [1:0] strap_cnt_r;
	logic strap_done_r;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			strap_cnt_r <= 2'h0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			strap_done_r <= (strap_cnt_r == `STRAP_SETTLE);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			resp_r <= '0;
		end else if (!strap_done_r && strap_cnt_r == `STRAP_SETTLE) begin
			resp_r <= {8{strap_s}};
		end else if (ev_fire && wr_hit(ev_r, `REG_FAULT_RECOVERY_SELECT)) begin
			resp_r <= ev_r.data;
		end
	end

	// Read snapshot taken when the command byte is seen
	logic [7:0] rd_data_r;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rd_data_r <= `READ_UNMAPPED;
		end else if (ev_fire && ev_r.kind == EV_POINT) begin
			rd_data_r <= reg_read(ev_r.cmd, flags_r, mask_r, resp_r);
		end
	end

	// Power sequencing and protection
	pwr_state_t st_r;
	pwr_state_t st_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	fault_vec_t active;
	logic restart;

	always_comb begin
		active = fault_s & ~mask_r;
		st_nxt = st_r;
		cnt_nxt = cnt_r + CNT_W'(1);
		restart = 1'b0;
		unique case (st_r)
			PS_OFF: begin
				cnt_nxt = '0;
				if (enable_s && strap_done_r) begin
					st_nxt = PS_INIT;
				end
			end
			PS_INIT: begin
				if (cnt_r == CNT_W'(INIT_CYCLES - 1)) begin
					st_nxt = PS_RUN;
					restart = 1'b1;
				end
			end
			PS_RUN: begin
				cnt_nxt = '0;
				if (|active) begin
					if (|(active & ~resp_r)) begin
						st_nxt = PS_LATCHED;
					end else begin
						st_nxt = PS_HICCUP;
					end
				end
			end
			PS_HICCUP: begin
				if (cnt_r == CNT_W'(HICCUP_CYCLES - 1)) begin
					st_nxt = PS_RUN;
					restart = 1'b1;
				end
			end
			PS_LATCHED: begin
				cnt_nxt = '0;
			end
		endcase
		if (!enable_s) begin
			st_nxt = PS_OFF;
			cnt_nxt = '0;
			restart = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_r <= PS_OFF;
			cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			switching_on_out <= 1'b0;
			soft_start_out <= 1'b0;
			latched_off_out <= 1'b0;
		end else begin
			switching_on_out <= (st_nxt == PS_RUN);
			soft_start_out <= restart;
			latched_off_out <= (st_nxt == PS_LATCHED);
		end
	end

	// Alert pin: low while initializing or while any flag stands
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			fault_alert_out <= 1'b0;
			fault_alert_oe_n_out <= 1'b1;
		end else begin
			fault_alert_out <= 1'b0;
			fault_alert_oe_n_out <= ~((|flags_nxt) || (st_nxt == PS_INIT));
		end
	end

	// ---------------- Link clock domain ----------------

	logic lrst_n;

	bit_sync #(
		.WIDTH(1)
	) u_lrst_sync (
		.clk_in(smb_clk_in),
		.rst_n_in(1'b1),
		.d_in(rst_n_in),
		.q_out(lrst_n)
	);

	// Start: data falls while the link clock is high. The bus start hold time keeps
	// this flag stable well before the first clock rise of the frame.
	logic start_a_r;
	logic start_seen_r;
	logic start_pend;

	always_ff @(negedge smb_data_in) begin
		if (smb_clk_in) begin
			start_a_r <= ~start_seen_r;
		end
	end

	assign start_pend = (start_a_r != start_seen_r);

	link_phase_t phase_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] cmd_r;
	logic [7:0] rd_shift_r;
	logic ack_r;
	logic [7:0] byte_in;

	assign byte_in = {shift_r[6:0], smb_data_in};

	always_ff @(posedge smb_clk_in) begin
		if (!lrst_n) begin
			phase_r <= LK_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			rd_shift_r <= 8'h00;
			ack_r <= 1'b0;
			start_seen_r <= 1'b0;
			ev_r <= '{kind: EV_POINT, cmd: 8'h00, data: 8'h00};
			ev_tog_r <= 1'b0;
		end else if (start_pend) begin
			start_seen_r <= start_a_r;
			phase_r <= LK_ADDR;
			shift_r <= {7'h00, smb_data_in};
			bit_cnt_r <= 4'h1;
			ack_r <= 1'b0;
		end else if (bit_cnt_r < 4'h7) begin
			shift_r <= byte_in;
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end else if (bit_cnt_r == 4'h7) begin
			bit_cnt_r <= 4'h8;
			ack_r <= 1'b0;
			unique case (phase_r)
				LK_ADDR: begin
					if (byte_in[7:1] == SMB_ADDR) begin
						ack_r <= 1'b1;
						phase_r <= byte_in[0] ? LK_READ : LK_CMD;
						// Snapshot was taken several system cycles after the command byte
						rd_shift_r <= rd_data_r;
					end else begin
						phase_r <= LK_IDLE;
					end
				end
				LK_CMD: begin
					ack_r <= 1'b1;
					cmd_r <= byte_in;
					ev_r.kind <= (byte_in == `CMD_CLEAR_FAULTS) ? EV_CLEAR : EV_POINT;
					ev_r.cmd <= byte_in;
					ev_r.data <= 8'h00;
					ev_tog_r <= ~ev_tog_r;
					phase_r <= LK_DATA;
				end
				LK_DATA: begin
					ack_r <= 1'b1;
					ev_r.kind <= EV_WRITE;
					ev_r.cmd <= cmd_r;
					ev_r.data <= byte_in;
					ev_tog_r <= ~ev_tog_r;
					phase_r <= LK_IDLE;
				end
				LK_READ: begin
					ack_r <= 1'b0;
				end
				LK_IDLE: begin
					ack_r <= 1'b0;
				end
			endcase
		end else begin
			bit_cnt_r <= 4'h0;
			// Host answers a read byte; a not-acknowledge ends the read
			if (phase_r == LK_READ && !ack_r && smb_data_in) begin
				phase_r <= LK_IDLE;
			end
		end
	end

	// Data line is changed only while the link clock is low
	always_ff @(negedge smb_clk_in) begin
		if (!lrst_n) begin
			smb_data_out <= 1'b0;
			smb_data_oe_n_out <= 1'b1;
		end else begin
			smb_data_out <= 1'b0;
			smb_data_oe_n_out <= start_pend ||
				!((bit_cnt_r == 4'h8 && ack_r) ||
				(phase_r == LK_READ && bit_cnt_r < 4'h8 && !rd_shift_r[3'(~bit_cnt_r[2:0])]));
		end
	end

endmodule : fault_supervisor

`default_nettype wire

/* tb/fault_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_monitor #(
	parameter int INIT_CYCLES = 10,
	parameter int HICCUP_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Watched inputs
	input wire logic enable_in,
	input wire logic input_overvoltage_in,
	input wire logic output_undervoltage_in,
	input wire logic output_overvoltage_in,
	// Watched outputs
	input wire logic switching_on_out,
	input wire logic soft_start_out,
	input wire logic latched_off_out,
	input wire logic fault_alert_out,
	input wire logic fault_alert_oe_n_out,
	input wire logic smb_data_out
);
	localparam int INIT_MAX = INIT_CYCLES + 12;
	localparam int HIC_MAX = HICCUP_CYCLES + 8;
	logic any_fault;
	assign any_fault = input_overvoltage_in || output_undervoltage_in || output_overvoltage_in;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	fault_sets_alert_a: assert property ((enable_in && any_fault)[*6] |-> !fault_alert_oe_n_out)
		else $error("alert not pulled for fault");
	open_drain_a: assert property (fault_alert_out == 1'b0 && smb_data_out == 1'b0)
		else $error("open drain driven high");
	disable_clears_a: assert property (!enable_in[*6] |-> fault_alert_oe_n_out && !switching_on_out && !latched_off_out)
		else $error("disable left alert or state");
	init_alert_a: assert property ($rose(enable_in) ##1 enable_in[*4] |-> !fault_alert_oe_n_out)
		else $error("alert released during init");
	init_start_a: assert property ($rose(enable_in) |-> ##[1:INIT_MAX] (soft_start_out || !enable_in))
		else $error("no soft start after enable");
	start_runs_a: assert property (soft_start_out |-> ##[0:1] switching_on_out)
		else $error("soft start without switching");
	pulse_once_a: assert property (soft_start_out |=> !soft_start_out)
		else $error("soft start pulse too long");
	latch_holds_a: assert property (enable_in[*4] ##0 latched_off_out |=> latched_off_out && !switching_on_out)
		else $error("latch off left while enabled");
	hiccup_restart_a: assert property ($fell(switching_on_out) ##1 !latched_off_out
		|-> ##[1:HIC_MAX] (soft_start_out || !enable_in))
		else $error("hiccup did not restart");
	cover property (soft_start_out);
	cover property (latched_off_out);
	cover property ($fell(switching_on_out) ##1 !latched_off_out);
endmodule : fault_monitor

`default_nettype wire

/* tb/pmbus_host.sv */
`timescale 1ns/1ps
`default_nettype none

module pmbus_host #(
	parameter logic [6:0] ADDR = 7'h20
) (
	// Bus lines, data released when high
	output logic scl_out,
	output logic sda_out,
	input wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Data bits move only while the clock is low, start and stop change data with it high; clock rests high between frames
	task automatic bit_io(input logic b, output logic r);
		scl_out = 1'b0;
		#12 sda_out = b;
		#12 scl_out = 1'b1;
		#24 r = sda_in;
	endtask : bit_io
	task automatic start();
		scl_out = 1'b0;
		#12 sda_out = 1'b1;
		#12 scl_out = 1'b1;
		#24 sda_out = 1'b0;
		#24;
	endtask : start
	task automatic stop();
		scl_out = 1'b0;
		#12 sda_out = 1'b0;
		#12 scl_out = 1'b1;
		#24 sda_out = 1'b1;
		#12;
	endtask : stop
	task automatic xfer(input logic [8:0] t, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) bit_io(t[i], r[i]);
	endtask : xfer
	task automatic wr(input logic [7:0] c, input logic [7:0] d, output logic ok);
		logic [8:0] a, b, e;
		start();
		xfer({ADDR, 2'b01}, a);
		xfer({c, 1'b1}, b);
		xfer({d, 1'b1}, e);
		stop();
		ok = !(a[0] || b[0] || e[0]);
	endtask : wr
	task automatic clr(output logic ok);
		logic [8:0] a, b;
		start();
		xfer({ADDR, 2'b01}, a);
		xfer(9'h007, b);
		stop();
		ok = !(a[0] || b[0]);
	endtask : clr
	// Host answers the read byte with a not-acknowledge
	task automatic rd(input logic [7:0] c, output logic [7:0] v, output logic ok);
		logic [8:0] a, b, e, r;
		start();
		xfer({ADDR, 2'b01}, a);
		xfer({c, 1'b1}, b);
		start();
		xfer({ADDR, 2'b11}, e);
		xfer(9'h1ff, r);
		stop();
		v = r[8:1];
		ok = !(a[0] || b[0] || e[0]);
	endtask : rd
endmodule : pmbus_host

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fault_map.svh"

module tb_top;
	logic mclk_in, rst_n_in, enable_in, strap, scl, sda_h, ok;
	logic [7:0] flt, v;
	logic switching_on_out, soft_start_out, latched_off_out, fault_alert_out, fault_alert_oe_n_out;
	logic smb_data_out, smb_data_oe_n_out;
	int miscompares = 0;
	int checked = 0;
	wire logic sda_w = sda_h && (smb_data_oe_n_out || smb_data_out);

	fault_supervisor #(.INIT_CYCLES(10), .HICCUP_CYCLES(20)) uut (.mclk_in, .rst_n_in, .enable_in,
		.recovery_default_pin_in(strap), .input_overvoltage_in(flt[2]), .output_undervoltage_in(flt[6]),
		.output_overvoltage_in(flt[7]), .other_fault_in(flt), .switching_on_out, .soft_start_out,
		.latched_off_out, .fault_alert_out, .fault_alert_oe_n_out, .smb_clk_in(scl), .smb_data_in(sda_w),
		.smb_data_out, .smb_data_oe_n_out);
	pmbus_host #(.ADDR(`SMB_ADDR_DEFAULT)) host (.scl_out(scl), .sda_out(sda_h), .sda_in(sda_w));

	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : cyc
	task rd(input logic [7:0] c, input logic [7:0] e);
		host.rd(c, v, ok);
		chk(v, e);
		chk({7'h00, ok}, 8'h01);
		// Realign to the falling edge before the next stimulus
		cyc(1);
	endtask : rd
	task wr(input logic [7:0] c, input logic [7:0] d);
		host.wr(c, d, ok);
		chk({7'h00, ok}, 8'h01);
		cyc(10);
	endtask : wr
	// Packs alert release, switching and latch-off
	task pins(input logic [7:0] e);
		chk({5'h00, fault_alert_oe_n_out, switching_on_out, latched_off_out}, e);
	endtask : pins
	task complete_run();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task ss(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk_in);
			if (soft_start_out === 1'b1) return;
		end
		miscompares++;
		complete_run();
	endtask : ss
	task boot();
		enable_in = 1'b1;
		cyc(5);
		pins(8'h00);
		ss(40);
		cyc(2);
		pins(8'h06);
	endtask : boot
	// Link clock must toggle around reset so the link side sees it
	task reset_dut();
		rst_n_in = 1'b0;
		fork
			begin host.stop(); host.stop(); end
			cyc(4);
		join
		rst_n_in = 1'b1;
		host.stop();
		host.stop();
		cyc(8);
	endtask : reset_dut

	initial begin
		enable_in = 1'b0;
		flt = 8'h00;
		strap = 1'b1;
		reset_dut();
		rd(`REG_FAULT_FLAGS, 8'h00);
		rd(`REG_FAULT_IGNORE_MASK, 8'h40);
		rd(`REG_FAULT_RECOVERY_SELECT, 8'hff);
		rd(8'hd5, 8'h00);
		boot();
		flt = 8'h40;
		cyc(6);
		pins(8'h02);
		flt = 8'h00;
		cyc(6);
		rd(`REG_FAULT_FLAGS, 8'h40);
		wr(`REG_FAULT_IGNORE_MASK, 8'hff);
		rd(`REG_FAULT_IGNORE_MASK, 8'hff);
		for (int i = 0; i < 8; i++) begin
			flt = 8'h01 << i;
			cyc(6);
			flt = 8'h00;
			cyc(2);
		end
		rd(`REG_FAULT_FLAGS, 8'hff);
		pins(8'h02);
		wr(`REG_FAULT_FLAGS, 8'h7f);
		rd(`REG_FAULT_FLAGS, 8'h80);
		pins(8'h02);
		wr(`REG_FAULT_FLAGS, 8'h80);
		pins(8'h06);
		flt = 8'h0c;
		cyc(6);
		flt = 8'h00;
		host.clr(ok);
		chk({7'h00, ok}, 8'h01);
		cyc(10);
		rd(`REG_FAULT_FLAGS, 8'h00);
		wr(`REG_FAULT_IGNORE_MASK, 8'h00);
		flt = 8'h80;
		cyc(15);
		pins(8'h00);
		ss(30);
		ss(40);
		flt = 8'h00;
		ss(40);
		cyc(6);
		pins(8'h02);
		wr(`REG_FAULT_RECOVERY_SELECT, 8'h7f);
		rd(`REG_FAULT_RECOVERY_SELECT, 8'h7f);
		flt = 8'h80;
		cyc(6);
		flt = 8'h00;
		cyc(30);
		pins(8'h01);
		rd(`REG_FAULT_FLAGS, 8'h80);
		enable_in = 1'b0;
		cyc(6);
		pins(8'h04);
		rd(`REG_FAULT_FLAGS, 8'h00);
		boot();
		// Mid-run reset with the strap low: response defaults to latch-off
		strap = 1'b0;
		reset_dut();
		ss(40);
		rd(`REG_FAULT_RECOVERY_SELECT, 8'h00);
		rd(`REG_FAULT_IGNORE_MASK, 8'h40);
		rd(`REG_FAULT_FLAGS, 8'h00);
		pins(8'h06);
		complete_run();
	end
endmodule : tb_top

bind fault_supervisor fault_monitor #(.INIT_CYCLES(INIT_CYCLES), .HICCUP_CYCLES(HICCUP_CYCLES)) mon (
	.mclk_in, .rst_n_in, .enable_in, .input_overvoltage_in, .output_undervoltage_in, .output_overvoltage_in,
	.switching_on_out, .soft_start_out, .latched_off_out, .fault_alert_out, .fault_alert_oe_n_out, .smb_data_out);

`default_nettype wire
